// >>> core/prr_pkg.sv
// Shared constants and types for the packet retry recovery block.
// Assumes a single port logic clock and an APB register slave.

package prr_pkg;

	// ==========================================================
	// Register map, byte addresses on the APB.
	localparam logic [11:0] PRR_OFS_CTRL = 12'h000; // Port enables.
	localparam logic [11:0] PRR_OFS_STATUS = 12'h004; // Machine states and status bits.
	localparam logic [11:0] PRR_OFS_ACKID = 12'h008; // AckID views.
	localparam logic [11:0] PRR_OFS_COUNT = 12'h00C; // Retry counters, write clears.

	// ==========================================================
	// Field positions.
	localparam int PRR_CTRL_IN_EN = 0; // Input port enable bit.
	localparam int PRR_CTRL_OUT_EN = 1; // Output port enable bit.
	localparam int PRR_ST_IN_LSB = 0; // Input machine state, two bits.
	localparam int PRR_ST_OUT_LSB = 2; // Output machine state, two bits.
	localparam int PRR_ST_NORMAL = 4; // Normal-operation status.
	localparam int PRR_ST_IN_RSTOP = 5; // Input retry-stopped status.
	localparam int PRR_ST_OUT_RSTOP = 6; // Output retry-stopped status.
	localparam int PRR_ACK_EXP_LSB = 0; // Expected ackID.
	localparam int PRR_ACK_NEXT_LSB = 8; // Next ackID to transmit.
	localparam int PRR_ACK_OLD_LSB = 16; // Oldest unacknowledged ackID.
	localparam int PRR_ACK_RET_LSB = 24; // AckID returned by the last retry.
	localparam int PRR_CNT_OUT_LSB = 16; // Output retry count half.

	// ==========================================================
	// Reset values and widths.
	localparam logic [1:0] PRR_CTRL_RST = 2'h0; // Both ports disabled.
	localparam int PRR_ACKID_W = 6; // AckID width on the link.
	localparam logic [PRR_ACKID_W-1:0] PRR_ACKID_RST = 6'h00; // AckID reset.

	// ==========================================================
	// Control symbol kinds seen on the link.
	typedef enum logic [2:0] {
		PRR_SYM_ACCEPTED = 3'h0, // Packet accepted.
		PRR_SYM_RETRY = 3'h1, // Packet retry.
		PRR_SYM_NOT_ACC = 3'h2, // Packet not accepted.
		PRR_SYM_RESTART_RETRY = 3'h3, // Restart from retry.
		PRR_SYM_LINKREQ_RESTART = 3'h4, // Link request, restart from error.
		PRR_SYM_OTHER = 3'h7 // Anything else.
	} prr_sym_kind_t;

	// A received control symbol.
	typedef struct packed {
		logic valid; // Symbol present this cycle.
		logic err_free; // Symbol passed its checks.
		prr_sym_kind_t kind; // Symbol kind.
		logic [PRR_ACKID_W-1:0] ackid; // Carried ackID.
	} prr_sym_t;

	// Input machine states, Gray along the path.
	typedef enum logic [1:0] {
		PRR_IN_DIS = 2'h0,
		PRR_IN_WAIT = 2'h1,
		PRR_IN_STOP = 2'h3,
		PRR_IN_RSTOP = 2'h2
	} prr_in_st_t;

	// Output machine states, Gray along the path.
	typedef enum logic [1:0] {
		PRR_OUT_DIS = 2'h0,
		PRR_OUT_WAIT = 2'h1,
		PRR_OUT_STOP = 2'h3,
		PRR_OUT_REC = 2'h2
	} prr_out_st_t;

endpackage

// >>> core/prr_core.sv
// Packet retry recovery machines for one link port, with APB registers.
// Assumes link events come from port logic on pclk, so no synchronisers.
//
// What this block does
// RL1 - Input machine disabled after reset until enabled.
// RL2 - Input enable moves disabled to waiting.
// RL3 - Input disable returns waiting to disabled.
// RL4 - Unacceptable packet enters stop-input.
// RL5 - Send retry with expected ackID, drop packet.
// RL6 - Stop-input clears normal, sets input retry-stopped.
// RL7 - Stop-input done advances to retry-stopped.
// RL8 - Retry-stopped discards packets, holds expected ackID.
// RL9 - Restart or input error leaves retry-stopped.
// RL10 - Input error hands over to error recovery.
// RL11 - Output machine disabled until output enabled.
// RL12 - Only error-free retry symbol starts stop-output.
// RL13 - Stop-output clears normal, halts new packets.
// RL14 - Stop procedure done advances to recover.
// RL15 - Recover retransmits from the returned ackID.
// RL16 - Recover updates scoreboard, restores normal status.
// RL17 - Recover sends restart-from-retry symbol.
// RL18 - Output error in recover hands over.
// RL19 - Retransmission begun returns to waiting.
// RL20 - States held in reset-forced registers.

`timescale 1ns/1ps
`default_nettype none

module prr_core import prr_pkg::*; #(
	parameter int CNT_W = 16 // Width of each retry counter.
) (
	input wire logic pclk, // Port logic clock, 25 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire logic link_init_done, // Link initialisation complete.
	input wire prr_sym_t rx_sym, // Received control symbol.
	input wire logic rx_pkt_valid, // Incoming packet start.
	input wire logic rx_no_buffer, // Packet cannot be accepted now.
	input wire logic in_port_err, // Input port error detected.
	input wire logic out_port_err, // Output port error detected.
	input wire logic retry_sym_taken, // Retry symbol taken by transmitter.
	input wire logic tx_idle, // No packet transmission in progress.
	input wire logic tx_pkt_sent, // A packet was sent with next ackID.
	input wire logic tx_resumed, // Retransmission has begun.
	output logic send_retry, // Request to send a packet-retry symbol.
	output logic [PRR_ACKID_W-1:0] retry_ackid, // AckID carried by it.
	output logic pkt_accept_ff, // Packet accepted pulse.
	output logic pkt_drop_ff, // Packet dropped pulse.
	output logic in_err_handoff_ff, // Hand-over to input error recovery.
	output logic tx_hold, // Do not start new packets.
	output logic tx_rewind, // Rewind transmit pointer pulse.
	output logic [PRR_ACKID_W-1:0] tx_rewind_ackid, // Where to restart.
	output logic send_restart, // Send a restart-from-retry symbol.
	output logic out_err_handoff_ff, // Hand-over to output error recovery.
	output logic [PRR_ACKID_W-1:0] tx_next_ackid // Next ackID to assign.
);

	// ==========================================================
	// Parameter checks.
	if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
		$error("CNT_W must be between 1 and 16.");
	end

	// ==========================================================
	// State and status registers.
	logic [1:0] ctrl_ff; // Software port enables.
	prr_in_st_t in_st_ff; // Input retry machine.
	prr_out_st_t out_st_ff; // Output retry machine.
	logic port_normal_ff; // Normal-operation status.
	logic in_rstop_ff; // Input retry-stopped status.
	logic out_rstop_ff; // Output retry-stopped status.
	logic [PRR_ACKID_W-1:0] exp_ackid_ff; // Next expected inbound ackID.
	logic [PRR_ACKID_W-1:0] ret_ackid_ff; // AckID from last retry symbol.
	logic [PRR_ACKID_W-1:0] tx_next_ff; // Next outbound ackID.
	logic [PRR_ACKID_W-1:0] tx_old_ff; // Oldest outstanding ackID.
	logic rec_step_ff; // Recover has done its rewind.
	logic [CNT_W-1:0] in_cnt_ff; // Input retries issued.
	logic [CNT_W-1:0] out_cnt_ff; // Output retries received.
	logic [31:0] prdata_ff; // Registered read data.
	logic pslverr_ff; // Registered error answer.

	// ==========================================================
	// Decoded events.
	logic in_enable; // Input port enabled.
	logic out_enable; // Output port enabled.
	logic sym_ok; // Valid, error-free symbol this cycle.
	logic got_retry; // Error-free packet-retry received.
	logic got_restart; // Restart that ends retry-stopped.
	logic got_pna; // Packet-not-accepted received.
	logic got_acc; // Packet-accepted received.
	logic in_exit; // Retry-stopped exit condition.
	logic out_fail; // Output error during recover.
	logic in_enter_stop; // Input machine enters stop-input.
	logic apb_wr; // APB write access phase.
	logic apb_rd; // APB read setup phase.
	logic addr_hit; // Address is mapped.

	// Enables are gated by link initialisation so software cannot jump ahead.
	assign in_enable = ctrl_ff[PRR_CTRL_IN_EN] & link_init_done; // RL1
	assign out_enable = ctrl_ff[PRR_CTRL_OUT_EN] & link_init_done; // RL11
	assign sym_ok = rx_sym.valid & rx_sym.err_free;
	assign got_retry = sym_ok & (rx_sym.kind == PRR_SYM_RETRY); // RL12
	assign got_restart = sym_ok & ((rx_sym.kind == PRR_SYM_RESTART_RETRY) |
		(rx_sym.kind == PRR_SYM_LINKREQ_RESTART));
	assign got_pna = sym_ok & (rx_sym.kind == PRR_SYM_NOT_ACC);
	assign got_acc = sym_ok & (rx_sym.kind == PRR_SYM_ACCEPTED);
	assign in_exit = got_restart | in_port_err; // RL9
	assign out_fail = got_pna | out_port_err; // RL18
	assign in_enter_stop = (in_st_ff == PRR_IN_WAIT) & in_enable & rx_pkt_valid & rx_no_buffer; // RL4

	// ==========================================================
	// Input retry machine.
	// Disabling only takes effect from the waiting state, so a stop in
	// progress always completes its handshake with the partner.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_st_ff <= PRR_IN_DIS; // RL20
		end else begin
			unique case (in_st_ff)
				PRR_IN_DIS: begin
					if (in_enable) begin
						in_st_ff <= PRR_IN_WAIT; // RL2
					end
				end
				PRR_IN_WAIT: begin
					if (!in_enable) begin
						in_st_ff <= PRR_IN_DIS; // RL3
					end else if (in_enter_stop) begin
						in_st_ff <= PRR_IN_STOP; // RL4
					end
				end
				PRR_IN_STOP: begin
					if (retry_sym_taken) begin
						in_st_ff <= PRR_IN_RSTOP; // RL7
					end
				end
				PRR_IN_RSTOP: begin
					if (in_exit) begin
						in_st_ff <= PRR_IN_WAIT; // RL9
					end
				end
			endcase
		end
	end

	// The retry request stands until the transmitter takes it.
	assign send_retry = (in_st_ff == PRR_IN_STOP); // RL5
	assign retry_ackid = exp_ackid_ff; // RL5

	// ==========================================================
	// Inbound packet disposition and expected ackID.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exp_ackid_ff <= PRR_ACKID_RST;
			pkt_accept_ff <= 1'b0;
			pkt_drop_ff <= 1'b0;
		end else begin
			pkt_accept_ff <= 1'b0;
			pkt_drop_ff <= 1'b0;
			if (rx_pkt_valid) begin
				if (in_st_ff == PRR_IN_WAIT && in_enable && !rx_no_buffer) begin
					pkt_accept_ff <= 1'b1;
					exp_ackid_ff <= exp_ackid_ff + 1'b1;
				end else begin
					// Refused and stopped packets leave the ackID alone.
					pkt_drop_ff <= 1'b1; // RL5 RL8
				end
			end
		end
	end

	// An input error while stopped for retry goes to error recovery.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_err_handoff_ff <= 1'b0;
		end else begin
			in_err_handoff_ff <= (in_st_ff == PRR_IN_RSTOP) & in_port_err; // RL10
		end
	end

	// ==========================================================
	// Output retry machine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_st_ff <= PRR_OUT_DIS; // RL20
		end else begin
			unique case (out_st_ff)
				PRR_OUT_DIS: begin
					if (out_enable) begin
						out_st_ff <= PRR_OUT_WAIT; // RL11
					end
				end
				PRR_OUT_WAIT: begin
					if (!out_enable) begin
						out_st_ff <= PRR_OUT_DIS; // RL11
					end else if (got_retry) begin
						out_st_ff <= PRR_OUT_STOP; // RL12
					end
				end
				PRR_OUT_STOP: begin
					if (tx_idle) begin
						out_st_ff <= PRR_OUT_REC; // RL14
					end
				end
				PRR_OUT_REC: begin
					if (out_fail) begin
						out_st_ff <= PRR_OUT_WAIT; // RL18
					end else if (rec_step_ff && tx_resumed) begin
						out_st_ff <= PRR_OUT_WAIT; // RL19
					end
				end
			endcase
		end
	end

	// Recover rewinds once on its first cycle, then waits for retransmission to begin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_step_ff <= 1'b0;
		end else begin
			rec_step_ff <= (out_st_ff == PRR_OUT_REC) & !out_fail;
		end
	end

	// New packets stay held until the rewind has been issued.
	assign tx_hold = (out_st_ff == PRR_OUT_STOP) | ((out_st_ff == PRR_OUT_REC) & !rec_step_ff); // RL13
	assign tx_rewind = (out_st_ff == PRR_OUT_REC) & !rec_step_ff & !out_fail; // RL15
	assign tx_rewind_ackid = ret_ackid_ff; // RL15
	assign send_restart = tx_rewind; // RL17
	assign tx_next_ackid = tx_next_ff;

	// Hand-over pulse to the output error recovery machine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_err_handoff_ff <= 1'b0;
		end else begin
			out_err_handoff_ff <= (out_st_ff == PRR_OUT_REC) & out_fail; // RL18
		end
	end

	// ==========================================================
	// Outstanding ackID scoreboard.
	// Packets before the returned ackID count as accepted at rewind.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_ackid_ff <= PRR_ACKID_RST;
			tx_next_ff <= PRR_ACKID_RST;
			tx_old_ff <= PRR_ACKID_RST;
		end else begin
			if (out_st_ff == PRR_OUT_WAIT && out_enable && got_retry) begin
				ret_ackid_ff <= rx_sym.ackid;
			end
			if (tx_rewind) begin
				tx_next_ff <= ret_ackid_ff; // RL16
				tx_old_ff <= ret_ackid_ff; // RL16
			end else begin
				if (tx_pkt_sent) begin
					tx_next_ff <= tx_next_ff + 1'b1;
				end
				if (got_acc && tx_old_ff != tx_next_ff) begin
					tx_old_ff <= tx_old_ff + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Port status bits. Stop entry wins over restoring normal.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_rstop_ff <= 1'b0;
		end else if (in_enter_stop) begin
			in_rstop_ff <= 1'b1; // RL6
		end else if (in_st_ff == PRR_IN_RSTOP && in_exit) begin
			in_rstop_ff <= 1'b0; // RL9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_rstop_ff <= 1'b0;
		end else if (out_st_ff == PRR_OUT_WAIT && out_enable && got_retry) begin
			out_rstop_ff <= 1'b1; // RL13
		end else if (tx_rewind) begin
			out_rstop_ff <= 1'b0; // RL16
		end
	end

	// Normal is raised when a port first comes up or a stop ends.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_normal_ff <= 1'b0;
		end else if (in_enter_stop || (out_st_ff == PRR_OUT_WAIT && out_enable && got_retry)) begin
			port_normal_ff <= 1'b0; // RL6 RL13
		end else if ((in_st_ff == PRR_IN_RSTOP && in_exit) || tx_rewind) begin
			port_normal_ff <= 1'b1; // RL9 RL16
		end else if ((in_st_ff == PRR_IN_DIS && in_enable) || (out_st_ff == PRR_OUT_DIS && out_enable)) begin
			port_normal_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Retry counters, saturating. A counting event beats a clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_cnt_ff <= '0;
		end else if (in_enter_stop) begin
			if (in_cnt_ff != '1) begin
				in_cnt_ff <= in_cnt_ff + 1'b1;
			end
		end else if (apb_wr && paddr == PRR_OFS_COUNT) begin
			in_cnt_ff <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_cnt_ff <= '0;
		end else if (out_st_ff == PRR_OUT_WAIT && out_enable && got_retry) begin
			if (out_cnt_ff != '1) begin
				out_cnt_ff <= out_cnt_ff + 1'b1;
			end
		end else if (apb_wr && paddr == PRR_OFS_COUNT) begin
			out_cnt_ff <= '0;
		end
	end

	// ==========================================================
	// APB slave: zero wait states, read data from flip-flops.
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & !penable & !pwrite;
	assign addr_hit = (paddr == PRR_OFS_CTRL) | (paddr == PRR_OFS_STATUS) |
		(paddr == PRR_OFS_ACKID) | (paddr == PRR_OFS_COUNT);
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff & psel & penable;

	// Control register write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= PRR_CTRL_RST;
		end else if (apb_wr && paddr == PRR_OFS_CTRL) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	// Read data is captured in the setup cycle so the access phase shows it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_ff <= !addr_hit;
			prdata_ff <= 32'h00000000;
			if (apb_rd) begin
				unique case (paddr)
					PRR_OFS_CTRL: prdata_ff[1:0] <= ctrl_ff;
					PRR_OFS_STATUS: begin
						prdata_ff[PRR_ST_IN_LSB +: 2] <= in_st_ff;
						prdata_ff[PRR_ST_OUT_LSB +: 2] <= out_st_ff;
						prdata_ff[PRR_ST_NORMAL] <= port_normal_ff;
						prdata_ff[PRR_ST_IN_RSTOP] <= in_rstop_ff;
						prdata_ff[PRR_ST_OUT_RSTOP] <= out_rstop_ff;
					end
					PRR_OFS_ACKID: begin
						prdata_ff[PRR_ACK_EXP_LSB +: PRR_ACKID_W] <= exp_ackid_ff;
						prdata_ff[PRR_ACK_NEXT_LSB +: PRR_ACKID_W] <= tx_next_ff;
						prdata_ff[PRR_ACK_OLD_LSB +: PRR_ACKID_W] <= tx_old_ff;
						prdata_ff[PRR_ACK_RET_LSB +: PRR_ACKID_W] <= ret_ackid_ff;
					end
					PRR_OFS_COUNT: begin
						prdata_ff[0 +: CNT_W] <= in_cnt_ff;
						prdata_ff[PRR_CNT_OUT_LSB +: CNT_W] <= out_cnt_ff;
					end
					default: prdata_ff <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks on the machines.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_in_dis_hold: assert property ((in_st_ff == PRR_IN_DIS && !in_enable) |=> in_st_ff == PRR_IN_DIS) // RL1
		else $error("Input machine left disabled without enable.");
	chk_in_enable_go: assert property ((in_st_ff == PRR_IN_DIS && in_enable) |=> in_st_ff == PRR_IN_WAIT) // RL2
		else $error("Input machine did not reach waiting on enable.");
	chk_in_disable_back: assert property ((in_st_ff == PRR_IN_WAIT && !in_enable) |=> in_st_ff == PRR_IN_DIS) // RL3
		else $error("Input machine ignored disable.");
	chk_stop_status: assert property (in_enter_stop |=> in_st_ff == PRR_IN_STOP && in_rstop_ff && !port_normal_ff
		&& send_retry) // RL4 RL6
		else $error("Stop-input entry did not set status.");
	chk_rstop_ackid: assert property ((in_st_ff == PRR_IN_RSTOP && rx_pkt_valid) |=> pkt_drop_ff
		&& $stable(exp_ackid_ff)) // RL8
		else $error("Packet not discarded while retry-stopped.");
	chk_rstop_exit: assert property ((in_st_ff == PRR_IN_RSTOP && in_exit) |=> in_st_ff == PRR_IN_WAIT
		&& !in_rstop_ff && port_normal_ff) // RL9
		else $error("Retry-stopped exit did not restore normal.");
	chk_out_stop_cause: assert property ((out_st_ff == PRR_OUT_WAIT && $past(out_st_ff) != PRR_OUT_WAIT
		&& $past(out_st_ff) != PRR_OUT_DIS) or out_st_ff != PRR_OUT_STOP or $past(out_st_ff) == PRR_OUT_STOP
		or $past(got_retry)) // RL12
		else $error("Stop-output entered without a clean retry symbol.");
	chk_out_hold: assert property (out_st_ff == PRR_OUT_STOP |-> tx_hold && out_rstop_ff && !port_normal_ff) // RL13
		else $error("Stop-output let new packets start.");
	chk_rec_restart: assert property (($rose(out_st_ff == PRR_OUT_REC) && !out_fail) |-> tx_rewind && send_restart
		&& tx_rewind_ackid == ret_ackid_ff ##1 tx_next_ff == $past(ret_ackid_ff) && !out_rstop_ff) // RL15 RL16 RL17
		else $error("Recover did not rewind and send restart.");
	chk_rec_handoff: assert property ((out_st_ff == PRR_OUT_REC && out_fail) |=> out_err_handoff_ff
		&& out_st_ff == PRR_OUT_WAIT) // RL18
		else $error("Output error in recover not handed over.");

endmodule

`default_nettype wire

// >>> test/prr_link_partner.sv
// Behavioural model of the attached port's transmit side facing the retry block.
// Assumes every input comes from the block or the bench on pclk; dly sets how slowly it answers.

`timescale 1ns/1ps
`default_nettype none

module prr_link_partner import prr_pkg::*; (
	input wire logic pclk, // Port logic clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic [2:0] dly, // Answer delay in cycles, zero is prompt.
	input wire logic send_retry, // Retry symbol requested by the block.
	input wire logic tx_pkt_sent, // A packet left the transmitter.
	input wire logic tx_rewind, // Retransmission requested by the block.
	output logic retry_sym_taken, // Retry symbol taken, one-cycle pulse.
	output logic tx_idle, // No packet in flight.
	output logic tx_resumed // Retransmission begun, one-cycle pulse.
);

	// ==========================================================
	// State of the three answers.
	logic [2:0] rcnt_ff; // Cycles spent on the pending retry symbol.
	logic [3:0] icnt_ff; // Cycles left until the packet in flight ends.
	logic [2:0] tcnt_ff; // Cycles since the rewind request.
	logic rew_ff; // A rewind is being served.

	// Take the retry symbol after dly cycles; a pulse, so it is never taken twice.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_ff <= 3'h0;
			retry_sym_taken <= 1'b0;
		end else if (!send_retry || retry_sym_taken) begin
			rcnt_ff <= 3'h0;
			retry_sym_taken <= 1'b0;
		end else begin
			rcnt_ff <= rcnt_ff + 3'h1;
			retry_sym_taken <= (rcnt_ff == dly);
		end
	end

	// A sent packet keeps the transmitter busy, so the stop procedure has to wait for it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			icnt_ff <= 4'h0;
		end else if (tx_pkt_sent) begin
			icnt_ff <= {dly, 1'b1};
		end else if (icnt_ff != 4'h0) begin
			icnt_ff <= icnt_ff - 4'h1;
		end
	end
	assign tx_idle = (icnt_ff == 4'h0);

	// Retransmission starts dly+2 cycles after the rewind request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcnt_ff <= 3'h0;
			rew_ff <= 1'b0;
			tx_resumed <= 1'b0;
		end else if (tx_rewind) begin
			tcnt_ff <= 3'h0;
			rew_ff <= 1'b1;
			tx_resumed <= 1'b0;
		end else if (rew_ff) begin
			tcnt_ff <= tcnt_ff + 3'h1;
			rew_ff <= (tcnt_ff != dly);
			tx_resumed <= (tcnt_ff == dly);
		end else begin
			tx_resumed <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the retry block: APB tasks and link event sequences.
// Assumes the link partner model answers the transmit side; the bench drives the receive side.

`timescale 1ns/1ps
`default_nettype none

module tb_top import prr_pkg::*;;

	// ==========================================================
	// Stimulus and observed signals.
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic link_init_done = 1'b0, rx_pkt_valid = 1'b0, rx_no_buffer = 1'b0;
	logic in_port_err = 1'b0, out_port_err = 1'b0, tx_pkt_sent = 1'b0, serr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [2:0] dly = 3'h0;
	prr_sym_t rx_sym = '0;
	logic pready, pslverr, send_retry, pkt_accept_ff, pkt_drop_ff, in_err_handoff_ff, tx_hold, tx_rewind;
	logic send_restart, out_err_handoff_ff, retry_sym_taken, tx_idle, tx_resumed;
	logic [PRR_ACKID_W-1:0] retry_ackid, tx_rewind_ackid, tx_next_ackid;
	int n_fail = 0, n_checks = 0;

	prr_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.link_init_done, .rx_sym, .rx_pkt_valid, .rx_no_buffer, .in_port_err, .out_port_err,
		.retry_sym_taken, .tx_idle, .tx_pkt_sent, .tx_resumed, .send_retry, .retry_ackid, .pkt_accept_ff,
		.pkt_drop_ff, .in_err_handoff_ff, .tx_hold, .tx_rewind, .tx_rewind_ackid, .send_restart,
		.out_err_handoff_ff, .tx_next_ackid);
	prr_link_partner peer (.pclk, .presetn, .dly, .send_retry, .tx_pkt_sent, .tx_rewind,
		.retry_sym_taken, .tx_idle, .tx_resumed);

	initial begin
		forever #20 pclk = ~pclk;
	end

	// ==========================================================
	// Shared tasks.
	task end_sim();
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; held until pready is seen high at a rising edge.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_fail++;
			end_sim();
		end
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// Packet start, with or without a free buffer; outputs checked after the sampling edge.
	task pkt(input logic nb);
		@(posedge pclk);
		rx_pkt_valid <= 1'b1;
		rx_no_buffer <= nb;
		@(posedge pclk);
		rx_pkt_valid <= 1'b0;
		rx_no_buffer <= 1'b0;
		#1;
	endtask

	task sym(input prr_sym_kind_t k, input logic ok, input logic [5:0] a);
		@(posedge pclk);
		rx_sym <= '{valid: 1'b1, err_free: ok, kind: k, ackid: a};
		@(posedge pclk);
		rx_sym <= '0;
		#1;
	endtask

	// Bounded wait: 0 retry symbol gone, 1 rewind seen, 2 retransmission begun.
	task waitsig(input int w);
		int i;
		i = 0;
		do begin
			@(posedge pclk);
			#1;
			i++;
		end while (!((w == 0 && send_retry === 1'b0) || (w == 1 && tx_rewind === 1'b1)
			|| (w == 2 && tx_resumed === 1'b1)) && i < 60);
		if (i >= 60) begin
			n_fail++;
			end_sim();
		end
	endtask

	initial begin
		repeat (50000) @(posedge pclk);
		n_fail++;
		end_sim();
	end

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(PRR_OFS_STATUS, 32'h0);
		rd_chk(PRR_OFS_ACKID, 32'h0);
		apb(1'b1, PRR_OFS_CTRL, 32'h3);
		rd_chk(PRR_OFS_STATUS, 32'h0);
		@(posedge pclk);
		link_init_done <= 1'b1;
		rd_chk(PRR_OFS_STATUS, 32'h15);
		rd_chk(12'h010, 32'h0);
		chk(serr, 1'b1);
		pkt(1'b0);
		chk(pkt_accept_ff, 1'b1);
		// Every way out of retry-stopped: restart, link request, input error.
		for (int c = 0; c < 3; c++) begin
			dly <= (c == 0) ? 3'h6 : 3'h0;
			pkt(1'b1);
			chk({send_retry, pkt_drop_ff, pkt_accept_ff, 2'b0, retry_ackid}, 32'h601);
			if (c == 0) rd_chk(PRR_OFS_STATUS, 32'h27);
			waitsig(0);
			rd_chk(PRR_OFS_STATUS, 32'h26);
			pkt(1'b1);
			chk({pkt_drop_ff, pkt_accept_ff, retry_ackid}, 32'h81);
			if (c == 0) sym(PRR_SYM_RESTART_RETRY, 1'b1, 6'h00);
			if (c == 1) sym(PRR_SYM_LINKREQ_RESTART, 1'b1, 6'h00);
			if (c == 2) begin
				@(posedge pclk);
				in_port_err <= 1'b1;
				@(posedge pclk);
				in_port_err <= 1'b0;
				#1;
				chk(in_err_handoff_ff, 1'b1);
			end
			rd_chk(PRR_OFS_STATUS, 32'h15);
		end
		apb(1'b1, PRR_OFS_CTRL, 32'h2);
		rd_chk(PRR_OFS_STATUS, 32'h14);
		apb(1'b1, PRR_OFS_CTRL, 32'h3);
		repeat (3) begin
			@(posedge pclk);
			tx_pkt_sent <= 1'b1;
			@(posedge pclk);
			tx_pkt_sent <= 1'b0;
		end
		#1;
		chk(tx_next_ackid, 32'h3);
		sym(PRR_SYM_RETRY, 1'b0, 6'h01);
		chk(tx_hold, 1'b0);
		dly <= 3'h4;
		@(posedge pclk);
		tx_pkt_sent <= 1'b1;
		@(posedge pclk);
		tx_pkt_sent <= 1'b0;
		sym(PRR_SYM_RETRY, 1'b1, 6'h01);
		chk(tx_hold, 1'b1);
		rd_chk(PRR_OFS_STATUS, 32'h4D);
		dly <= 3'h7;
		waitsig(1);
		chk({send_restart, 2'b0, tx_rewind_ackid}, 32'h101);
		@(posedge pclk);
		#1;
		chk({tx_hold, 2'b0, tx_next_ackid}, 32'h001);
		rd_chk(PRR_OFS_STATUS, 32'h19);
		waitsig(2);
		rd_chk(PRR_OFS_STATUS, 32'h15);
		sym(PRR_SYM_RETRY, 1'b1, 6'h02);
		waitsig(1);
		@(posedge pclk);
		out_port_err <= 1'b1;
		@(posedge pclk);
		out_port_err <= 1'b0;
		#1;
		chk(out_err_handoff_ff, 1'b1);
		apb(1'b0, PRR_OFS_STATUS, 32'h0);
		chk(q[3:2], 2'h1);
		rd_chk(PRR_OFS_COUNT, 32'h0002_0003);
		apb(1'b1, PRR_OFS_COUNT, 32'h0);
		rd_chk(PRR_OFS_COUNT, 32'h0);
		end_sim();
	end

endmodule

`default_nettype wire
